//--- include/ddh_pkg.sv
/*
 * Constants shared by the two-wire master that drives the display driver's serial slave port.
 * The device sits on an open-drain bus with pull-ups; the bench resolves the wire levels.
 */
// Summary of operation
// - idle bus leaves both clock and data released high.
// - start is data falling while clock is high.
// - stop is data rising while clock is high; bus then free again.
// - one bit per clock pulse; data stable while clock high.
// - ninth clock carries acknowledge; receiver holds data low in high phase.
// - device acknowledges written bytes; master acknowledges bytes it reads; the code leaves the last read byte unacknowledged.
// - master starts every transfer and makes the clock.
// - first byte is seven address bits plus direction, low write, high read.
// - write is address then command byte selecting register, then optional data.
// - master never writes command location 6.
// - read reuses stored pointer; master first writes command byte only.
package ddh_pkg;
    localparam logic [2:0] ADDR_FIXED      = 3'h5;  // upper address bits 101
    localparam logic [6:0] CMD_RESERVED    = 7'h06;
    localparam int         LINK_DIV        = 4;     // clk cycles per quarter bit
    localparam int         NBITS           = 9;     // byte plus acknowledge
    localparam logic [3:0] BIT_LAST        = 4'h8;

    typedef enum logic [3:0] {
        DDH_IDLE, DDH_START, DDH_BIT, DDH_NEXT, DDH_STOP, DDH_DONE
    } ddh_state_e;
endpackage

//--- hdl/ddh_master.sv
/*
 * Two-wire bus master for the display driver's serial port.
 * Issues one transfer per request: address byte, then n bytes written or read.
 * Assumes external pull-ups; pins are split into in/out/enable triples.
 * The bus clock is made here by a divider, so there is one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module ddh_master (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       clk_en,
    // user side
    input  wire logic       req_valid,       // start a transfer
    output logic            req_ready,
    input  wire logic       req_read,        // 1 read, 0 write
    input  wire logic [1:0] addr_strap_upper_input,
    input  wire logic [1:0] addr_strap_lower_input,
    input  wire logic [3:0] req_count,       // bytes after address, 1..15
    input  wire logic [7:0] wr_data,         // byte to send
    output logic            wr_take,         // pulse: wr_data consumed
    output logic [7:0]      rd_data,
    output logic            rd_valid,        // pulse: rd_data new
    output logic            done,            // pulse: stop sent
    output logic            nack_err,        // level until next request
    // bus pins
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sda_sync_q;
    logic [1:0] scl_sync_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sda_sync_q <= 2'h3;
            scl_sync_q <= 2'h3;
        end else if (clk_en) begin
            sda_sync_q <= {sda_sync_q[0], sda_in};
            scl_sync_q <= {scl_sync_q[0], scl_in};
        end
    end
    wire sda_s = sda_sync_q[1];
    wire scl_s = scl_sync_q[1];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ddh_pkg::ddh_state_e st_q;
    logic [1:0] ph_q;          // quarter of bit: 0 low,1 low,2 high,3 high
    logic [2:0] div_q;
    logic [3:0] bit_q;
    logic [3:0] left_q;        // data bytes still to go
    logic       first_q;       // address byte in flight
    logic       rd_q;
    logic [7:0] sh_q;
    logic       scl_lo_q;      // driving clock low
    logic       sda_lo_q;      // driving data low
    logic       nack_q;
    logic [6:0] addr_q;

    wire [6:0] dev_addr = {ddh_pkg::ADDR_FIXED, addr_strap_upper_input, addr_strap_lower_input};
    wire       tick     = (div_q == 3'(ddh_pkg::LINK_DIV - 1));
    wire       in_ack   = (bit_q == ddh_pkg::BIT_LAST);
    // receiving means a data byte of a read; the address byte is always sent
    wire       rx_byte  = rd_q && !first_q;
    wire       last     = (left_q == 4'h1);
    // a new frame only opens once both lines read back high
    // no clock stretching: a slave holding scl low only delays the next start
    wire       bus_free = scl_s && sda_s;
    // command byte aimed at the reserved location; top bit is ignored like the device does
    wire       cmd_reserved = !rd_q && first_q && (wr_data[6:0] == ddh_pkg::CMD_RESERVED);

    // data line value for this bit, low on zero or on own ack
    // master acks every read byte except the last
    wire sda_drive_bit = in_ack ? (rx_byte && !last) : (!rx_byte && !sh_q[7]);

    assign req_ready = (st_q == ddh_pkg::DDH_IDLE) && bus_free;
    assign scl_out   = 1'b0;
    assign sda_out   = 1'b0;
    assign scl_oe    = scl_lo_q;
    assign sda_oe    = sda_lo_q;
    assign nack_err  = nack_q;

    // quarter-bit divider; parked at zero while idle so each frame starts on a whole quarter
    // the enable gates the idle clear too, otherwise a frozen block would still move
    always_ff @(posedge clk) begin
        if (sys_rst)
            div_q <= 3'h0;
        else if (clk_en)
            div_q <= (tick || st_q == ddh_pkg::DDH_IDLE) ? 3'h0 : div_q + 3'h1;
    end

    // ------------------------------------------------------------
    // bit engine
    // ------------------------------------------------------------
    // master makes clock and opens transfers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q     <= ddh_pkg::DDH_IDLE;
            ph_q     <= 2'h0;
            bit_q    <= 4'h0;
            left_q   <= 4'h0;
            first_q  <= 1'b0;
            rd_q     <= 1'b0;
            sh_q     <= 8'h00;
            scl_lo_q <= 1'b0;
            sda_lo_q <= 1'b0;
            nack_q   <= 1'b0;
            addr_q   <= 7'h00;
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
            wr_take  <= 1'b0;
            done     <= 1'b0;
        end else if (clk_en) begin
            rd_valid <= 1'b0;
            wr_take  <= 1'b0;
            done     <= 1'b0;
            unique case (st_q)
                ddh_pkg::DDH_IDLE: begin
                    if (req_valid && req_ready && req_count != 4'h0) begin
                        addr_q  <= dev_addr;
                        sh_q    <= {dev_addr, req_read};
                        rd_q    <= req_read;
                        left_q  <= req_count;
                        first_q <= 1'b1;
                        nack_q  <= 1'b0;
                        ph_q    <= 2'h0;
                        st_q    <= ddh_pkg::DDH_START;
                    end
                end
                ddh_pkg::DDH_START: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h1) sda_lo_q <= 1'b1;
                    if (ph_q == 2'h3) begin
                        scl_lo_q <= 1'b1;
                        bit_q    <= 4'h0;
                        st_q     <= ddh_pkg::DDH_BIT;
                    end
                end
                ddh_pkg::DDH_BIT: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    // data changes only while clock low
                    if (ph_q == 2'h0) sda_lo_q <= sda_drive_bit;
                    if (ph_q == 2'h1) scl_lo_q <= 1'b0;
                    if (ph_q == 2'h2) begin
                        if (in_ack) begin
                            if (!rx_byte && sda_s) nack_q <= 1'b1;
                        end else
                            sh_q <= {sh_q[6:0], sda_s};
                    end
                    if (ph_q == 2'h3) begin
                        scl_lo_q <= 1'b1;
                        if (in_ack) st_q <= ddh_pkg::DDH_NEXT;
                        else bit_q <= bit_q + 4'h1;
                    end
                end
                ddh_pkg::DDH_NEXT: begin
                    bit_q <= 4'h0;
                    if (rx_byte) begin
                        rd_data  <= sh_q;
                        rd_valid <= 1'b1;
                    end
                    if (!first_q) left_q <= left_q - 4'h1;
                    first_q <= 1'b0;
                    // reserved command: stop before it reaches the bus, report as error
                    if (cmd_reserved) nack_q <= 1'b1;
                    if (nack_q || cmd_reserved || (!first_q && last)) begin
                        ph_q <= 2'h0;
                        st_q <= ddh_pkg::DDH_STOP;
                    end else begin
                        if (!rd_q) begin
                            sh_q    <= wr_data;
                            wr_take <= 1'b1;
                        end
                        st_q <= ddh_pkg::DDH_BIT;
                    end
                end
                ddh_pkg::DDH_STOP: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h0) sda_lo_q <= 1'b1;
                    if (ph_q == 2'h1) scl_lo_q <= 1'b0;
                    if (ph_q == 2'h2) sda_lo_q <= 1'b0;
                    if (ph_q == 2'h3) st_q <= ddh_pkg::DDH_DONE;
                end
                ddh_pkg::DDH_DONE: begin
                    done <= 1'b1;
                    st_q <= ddh_pkg::DDH_IDLE;
                end
                default: st_q <= ddh_pkg::DDH_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // idle lines
    chk_idle_lines: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == ddh_pkg::DDH_IDLE) |-> (!scl_oe && !sda_oe))
        else $error("bus not released while idle");
    chk_start_shape: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == ddh_pkg::DDH_START && $rose(sda_oe)) |-> !scl_oe)
        else $error("start taken with clock low");
    chk_stop_shape: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == ddh_pkg::DDH_STOP && $fell(sda_oe)) |-> !scl_oe)
        else $error("stop released data with clock low");
    chk_data_stable: assert property (@(posedge clk) disable iff (sys_rst)
        (!scl_oe && !$past(scl_oe) && st_q == ddh_pkg::DDH_BIT) |-> $stable(sda_oe))
        else $error("data moved while clock high");
    chk_nine_bits: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == ddh_pkg::DDH_BIT) |-> (bit_q <= ddh_pkg::BIT_LAST))
        else $error("more than nine bits in a byte");
    chk_master_ack: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == ddh_pkg::DDH_BIT && in_ack && rx_byte && !last && ph_q == 2'h2) |-> sda_oe)
        else $error("master failed to acknowledge read byte");
    chk_addr_fixed: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q != ddh_pkg::DDH_IDLE) |-> (addr_q[6:4] == ddh_pkg::ADDR_FIXED))
        else $error("wrong fixed address bits");
    chk_nack_stop: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
        (st_q == ddh_pkg::DDH_NEXT && nack_q) |=> (st_q == ddh_pkg::DDH_STOP))
        else $error("no stop after missing acknowledge");
    cov_write: cover property (@(posedge clk) done && !rd_q && !nack_q);
    cov_read:  cover property (@(posedge clk) rd_valid ##[1:300] done);
    cov_nack:  cover property (@(posedge clk) done && nack_q);
    cov_refused: cover property (@(posedge clk) st_q == ddh_pkg::DDH_NEXT && cmd_reserved);
    // device acks writes
    // the master must let go of data or it would mask a missing acknowledge
    chk_ack_release: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == ddh_pkg::DDH_BIT && in_ack && !rx_byte && ph_q == 2'h2) |-> !sda_oe)
        else $error("master held data during device acknowledge");
    chk_last_nack: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == ddh_pkg::DDH_BIT && in_ack && rx_byte && last && ph_q == 2'h2) |-> !sda_oe)
        else $error("master acknowledged the final read byte");
    chk_ack_hold: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == ddh_pkg::DDH_BIT && in_ack && rx_byte && !last && ph_q == 2'h3) |-> sda_oe)
        else $error("master acknowledge dropped during clock high");
    chk_nack_flag: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
        (st_q == ddh_pkg::DDH_BIT && in_ack && !rx_byte && ph_q == 2'h2 && tick && sda_s) |=> nack_q)
        else $error("missing acknowledge not flagged");
    chk_clock_rise: assert property (@(posedge clk) disable iff (sys_rst)
        ($fell(scl_oe) && st_q == ddh_pkg::DDH_BIT) |-> (ph_q == 2'h2))
        else $error("clock released outside its quarter");
    chk_setup: assert property (@(posedge clk) disable iff (sys_rst)
        ($fell(scl_oe) && st_q == ddh_pkg::DDH_BIT) |-> $stable(sda_oe))
        else $error("data moved as clock was released");
    chk_start_idle: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
        (st_q == ddh_pkg::DDH_IDLE && req_valid && req_ready && req_count != 4'h0)
        |=> (st_q == ddh_pkg::DDH_START && !scl_oe && !sda_oe))
        else $error("accepted request did not open a frame");
    chk_bus_free: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == ddh_pkg::DDH_START && ph_q == 2'h0) |-> (scl_s && sda_s))
        else $error("frame opened on a busy bus");
    chk_done_free: assert property (@(posedge clk) disable iff (sys_rst)
        done |-> (!scl_oe && !sda_oe))
        else $error("lines still held after stop");
    chk_no_reserved: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
        (st_q == ddh_pkg::DDH_NEXT && first_q && !rd_q && !nack_q)
        |=> (st_q == ddh_pkg::DDH_STOP || sh_q[6:0] != ddh_pkg::CMD_RESERVED))
        else $error("reserved command location sent");
endmodule
`default_nettype wire

//--- tb/ddh_dev_model.sv
/*
 * Behavioural display driver serial slave: address match, command pointer, byte store.
 * Assumes pull-ups; the bench resolves scl and sda from every pull-down.
 */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// device model
// ------------------------------
module ddh_dev_model (
    input  wire logic       scl,      // only watched, never driven
    input  wire logic       sda,
    input  wire logic [3:0] strap,    // upper strap pair, lower strap pair
    output logic            sda_pull  // 1 pulls data low
);
    logic [7:0] mem [0:127];
    logic [7:0] sh;
    logic [6:0] ptr;
    logic [7:0] font_ptr;
    int         bitn;
    int         byten;
    logic       act, mine, rd, nak;
    initial begin
        for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ 8'h5a;
        {sda_pull, act, mine, rd, nak, ptr, font_ptr} = '0;
        bitn = 0;
        byten = 0;
    end
    // step; location 5 moves the font pointer instead
    task automatic step();
        if (ptr == 7'h05) font_ptr = font_ptr + 8'h01;
        else if (ptr != 7'h7f) ptr = ptr + 7'h01;
    endtask
    // start: data falls while clock high
    always @(negedge sda) if (scl) begin
        {act, mine, rd, nak} = 4'b1000;
        bitn = 0;
        byten = 0;
    end
    // stop: data rises while clock high, line let go
    always @(posedge sda) if (scl) begin
        act = 1'b0;
        sda_pull = 1'b0;
    end
    // sample on clock rise; ninth bit is the acknowledge
    always @(posedge scl) if (act) begin
        if (bitn < 8) begin
            sh = {sh[6:0], sda};
            bitn++;
        end else begin
            // address ack of a read does not step; only data bytes read do
            if (mine && rd && byten > 1) begin
                nak = sda;
                step();
            end
            if (mine && rd) byten++;
            bitn = 0;
        end
    end
    // act on clock fall, so the pull only changes while clock is low
    always @(negedge scl) if (act) begin
        sda_pull = 1'b0;
        if (bitn == 8 && !(rd && byten > 0)) begin
            if (byten == 0) begin
                mine = (sh[7:1] == {3'b101, strap});
                rd = sh[0];
            end else if (mine && byten == 1) ptr = sh[6:0];
            else if (mine) begin
                mem[ptr] = sh;
                step();
            end
            sda_pull = mine;
            byten++;
        end else if (bitn < 8 && mine && rd && byten > 0 && !nak) sda_pull = ~mem[ptr][7 - bitn];
    end
endmodule
`default_nettype wire

//--- tb/test_ddh_master.sv
/*
 * Self-checking bench: master against the device model on a resolved two-wire bus.
 * Assumes pull-ups; expected bytes come from a shadow of the device registers.
 */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// bench top
// ------------------------------
module test_ddh_master;
    logic       clk, sys_rst, req_valid, req_ready, req_read, wr_take, rd_valid, done, nack_err;
    logic       scl_out, scl_oe, sda_out, sda_oe, dev_pull;
    logic [3:0] req_count, m_strap, d_strap;
    logic [7:0] wr_data, rd_data;
    logic [7:0] wb [0:15];
    logic [7:0] shadow [0:127];
    logic [7:0] exp_q [$];
    logic [7:0] cmds [5] = '{8'h00, 8'h02, 8'h85, 8'h7c, 8'h47}; // never location 6
    int         lens [5] = '{2, 4, 4, 6, 8};
    int         fails, n_checks;
    wire logic  scl = scl_oe ? scl_out : 1'b1;
    wire logic  sda = (sda_oe ? sda_out : 1'b1) & ~dev_pull;
    ddh_master u_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .req_valid(req_valid),
        .req_ready(req_ready), .req_read(req_read), .addr_strap_upper_input(m_strap[3:2]),
        .addr_strap_lower_input(m_strap[1:0]), .req_count(req_count), .wr_data(wr_data),
        .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid), .done(done),
        .nack_err(nack_err), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
    ddh_dev_model u_dev (.scl(scl), .sda(sda), .strap(d_strap), .sda_pull(dev_pull));
    function automatic logic [6:0] nxt(input logic [6:0] p);
        return (p == 7'h05 || p == 7'h7f) ? p : p + 7'h01;
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // one transfer; next byte presented after each take, bounded wait for done
    task automatic xfer(input logic r, input logic [3:0] n, input logic nk);
        int k;
        int t;
        k = 0;
        t = 0;
        check("req_ready", {7'h0, req_ready}, 8'h01);
        req_read = r;
        req_count = n;
        wr_data = wb[0];
        req_valid = 1'b1;
        do begin
            @(negedge clk);
            req_valid = 1'b0;
            t++;
            if (t == 1) check("req_ready", {7'h0, req_ready}, 8'h00);
            if (wr_take === 1'b1 && k < 15) begin
                k++;
                wr_data = wb[k];
            end
        end while (done !== 1'b1 && t < 4000);
        if (t >= 4000) begin
            fails++;
            wrap_up();
        end
        check("nack_err", {7'h0, nack_err}, {7'h0, nk});
        @(negedge clk);
        check("bus_idle", {6'h0, scl, sda}, 8'h03);
    endtask
    // write n random bytes from command c, point back, read them again
    task automatic run(input logic [7:0] c, input int n);
        logic [6:0] p;
        p = c[6:0];
        wb[0] = c;
        for (int i = 1; i <= n; i++) begin
            wb[i] = 8'($urandom());
            shadow[p] = wb[i];
            p = nxt(p);
        end
        xfer(1'b0, 4'(n + 1), 1'b0);
        xfer(1'b0, 4'h1, 1'b0);
        p = c[6:0];
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(shadow[p]);
            p = nxt(p);
        end
        xfer(1'b1, 4'(n), 1'b0);
        check("queue_left", 8'(exp_q.size()), 8'h00);
        $display("test run %h done", c);
    endtask
    // oldest expected byte taken whenever a read byte appears
    always @(negedge clk) if (rd_valid === 1'b1) check("rd_data", rd_data, exp_q.pop_front());
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // watchdog: a few times the expected run length
    initial begin
        #1_000_000;
        fails++;
        wrap_up();
    end
    initial begin
        {sys_rst, req_valid, req_read, req_count, wr_data, m_strap, d_strap} = {3'b100, 20'h0};
        fails = 0;
        n_checks = 0;
        for (int i = 0; i < 128; i++) shadow[i] = 8'(i) ^ 8'h5a;
        void'($urandom(32'h8652));
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        // every strap pairing answers to a command-only write
        for (int i = 0; i < 16; i++) begin
            m_strap = 4'(i);
            d_strap = 4'(i);
            wb[0] = 8'h10;
            xfer(1'b0, 4'h1, 1'b0);
        end
        $display("test straps done");
        // foreign address gets no answer and changes nothing
        d_strap = ~m_strap;
        wb[0] = 8'h33;
        wb[1] = 8'hee;
        xfer(1'b0, 4'h2, 1'b1);
        d_strap = m_strap;
        exp_q.push_back(shadow[16]);
        xfer(1'b1, 4'h1, 1'b0);
        // reserved command refused before the device sees it; pointer stays put
        wb[0] = 8'h86;
        wb[1] = 8'h11;
        xfer(1'b0, 4'h2, 1'b1);
        exp_q.push_back(shadow[17]);
        xfer(1'b1, 4'h1, 1'b0);
        $display("test foreign done");
        foreach (cmds[i]) run(cmds[i], lens[i]);
        wrap_up();
    end
endmodule
`default_nettype wire
